// >>> verilog/fan_ctrl.sv
// Four-channel fan power controller with tach measurement
`timescale 1ns/10ps
`default_nettype none
`include "fan_map.svh"

module fan_ctrl
    import fan_pkg::*;
#(
    parameter int MS_CYC   = `FAN_MS_CYC,
    parameter int STEP_CYC = `FAN_STEP_CYC
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    // Register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Stored boot configuration
    input  wire logic        BOOT_SAVED,
    input  wire logic [31:0] BOOT_POWER,
    // Link and fans
    input  wire logic        LINK_OK,
    input  wire logic [3:0]  TACH,
    output logic      [3:0]  FAN_ON
);

    localparam logic [23:0] MS_LAST   = 24'(MS_CYC - 1);
    localparam logic [23:0] STEP_LAST = 24'(STEP_CYC - 1);
    localparam logic [6:0]  WIN_LAST  = 7'(`FAN_WIN_MS - 1);
    localparam logic [8:0]  GAP_MS    = 9'(`FAN_GAP_MS);

    ctrl_t           s;
    ctrl_t           next_s;
    logic            ms_tick;
    logic            step_tick;
    logic            win_end;
    logic [1:0]      next_idx;
    logic [3:0]      fs_act;
    logic [3:0]      tach_rise;
    logic [3:0]      force_v;
    logic [3:0][7:0] duty;

    // Out-of-range writes saturate rather than wrap
    function automatic logic [7:0] clamp(input logic [7:0] v);
        clamp = (v > `FAN_DUTY_FULL) ? `FAN_DUTY_FULL : v;
    endfunction : clamp

    // Time bases and window boundary
    assign ms_tick   = (s.ms_div == MS_LAST);
    assign step_tick = (s.step_div == STEP_LAST);
    assign win_end   = ms_tick && (s.slot_ms == WIN_LAST);
    assign next_idx  = 2'(s.meas_idx + 2'h1);

    // Per-fan override selection
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            fs_act[i] = s.fs_en[i] && (s.fs_tmo != 8'h00)
                        && (s.fs_cnt[i] >= s.fs_tmo);
            force_v[i] = s.stretch && (s.meas_idx == 2'(i));
            // Link loss and fail-safe both mean full power
            duty[i] = (!s.lk_s2 || fs_act[i]) ? `FAN_DUTY_FULL
                                              : s.power[i];
        end
    end

    // Next-state logic for the whole controller
    always_comb begin
        next_s       = s;
        next_s.rdata = 8'h00;

        // Link presence sync
        next_s.lk_s1 = LINK_OK;
        next_s.lk_s2 = s.lk_s1;

        // Millisecond tick and PWM phase
        next_s.ms_div   = ms_tick ? 24'h000000 : 24'(s.ms_div + 24'h1);
        next_s.step_div = step_tick ? 24'h000000
                                    : 24'(s.step_div + 24'h1);
        if (step_tick) begin
            next_s.pwm_cnt = (s.pwm_cnt == `FAN_PWM_LAST) ? 7'h00
                           : 7'(s.pwm_cnt + 7'h01);
        end

        // Boot load, then staggered start
        unique case (s.phase)
            PH_BOOT: begin
                if (BOOT_SAVED) begin
                    for (int i = 0; i < 4; i++) begin
                        next_s.power[i] = clamp(BOOT_POWER[8*i +: 8]);
                    end
                end
                next_s.phase = PH_START;
            end
            PH_START: begin
                if (s.gap_ms != 9'h000) begin
                    if (ms_tick) begin
                        next_s.gap_ms = 9'(s.gap_ms - 9'h001);
                    end
                end else if (s.st_idx[2]) begin
                    next_s.phase = PH_RUN;
                end else begin
                    next_s.started[s.st_idx[1:0]] = 1'b1;
                    // Idle fans draw no inrush, so no gap after them
                    if (s.power[s.st_idx[1:0]] != 8'h00) begin
                        next_s.gap_ms = GAP_MS;
                    end
                    next_s.st_idx = 3'(s.st_idx + 3'h1);
                end
            end
            PH_RUN: begin
                next_s.phase = PH_RUN;
            end
        endcase

        // Tach edges of the fan under measurement
        if (tach_rise[s.meas_idx]) begin
            if (s.tach_cnt != 8'hFF) begin
                next_s.tach_cnt = 8'(s.tach_cnt + 8'h01);
            end
            if (s.edges != 2'h2) begin
                next_s.edges = 2'(s.edges + 2'h1);
            end
        end
        if (ms_tick && (s.glitch_ms != 8'h00)) begin
            next_s.glitch_ms = 8'(s.glitch_ms - 8'h01);
        end
        if (s.stretch && (s.edges == 2'h2) && (s.glitch_ms == 8'h00)) begin
            next_s.stretch = 1'b0;
        end

        // Window boundary: latch result, step to the next fan
        if (win_end) begin
            next_s.tach_res[s.meas_idx] = s.tach_cnt;
            next_s.tach_cnt  = 8'h00;
            next_s.edges     = 2'h0;
            next_s.slot_ms   = 7'h00;
            next_s.meas_idx  = next_idx;
            next_s.glitch_ms = s.glitch;
            // Window end also caps any stretch at 125 ms
            next_s.stretch   = s.rpt_en[next_idx];
            for (int i = 0; i < 4; i++) begin
                if (s.fs_cnt[i] != 8'hFF) begin
                    next_s.fs_cnt[i] = 8'(s.fs_cnt[i] + 8'h01);
                end
            end
        end else if (ms_tick) begin
            next_s.slot_ms = 7'(s.slot_ms + 7'h01);
        end

        // A disabled fail-safe does not age, so enabling is not a trip
        for (int i = 0; i < 4; i++) begin
            if (!s.fs_en[i]) begin
                next_s.fs_cnt[i] = 8'h00;
            end
        end

        // Register writes; a power write is the host refresh
        if (WR) begin
            if (ADDR[3:2] == 2'b00) begin
                next_s.power[ADDR[1:0]]  = clamp(WDATA);
                next_s.fs_cnt[ADDR[1:0]] = 8'h00;
            end else begin
                unique case (ADDR)
                    `OFS_RPT_EN: next_s.rpt_en = WDATA[3:0];
                    `OFS_FS_EN:  next_s.fs_en  = WDATA[3:0];
                    `OFS_FS_TMO: next_s.fs_tmo = WDATA;
                    `OFS_GLITCH: next_s.glitch = WDATA;
                    default:     next_s.rdata  = 8'h00;
                endcase
            end
        end

        // Register reads, data valid the next cycle
        if (RD) begin
            if (ADDR[3:2] == 2'b00) begin
                next_s.rdata = s.power[ADDR[1:0]];
            end else if (ADDR[3:2] == 2'b10) begin
                next_s.rdata = s.tach_res[ADDR[1:0]];
            end else begin
                unique case (ADDR)
                    `OFS_RPT_EN: next_s.rdata = {4'h0, s.rpt_en};
                    `OFS_FS_EN:  next_s.rdata = {4'h0, s.fs_en};
                    `OFS_FS_TMO: next_s.rdata = s.fs_tmo;
                    `OFS_GLITCH: next_s.rdata = s.glitch;
                    `OFS_STATUS: next_s.rdata = {fs_act, s.started};
                    default:     next_s.rdata = 8'h00;
                endcase
            end
        end
    end

    // State register; power resets to full until boot load
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            s        <= '0;
            s.phase  <= PH_BOOT;
            s.power  <= {4{`FAN_DUTY_FULL}};
            s.fs_tmo <= `RST_FS_TMO;
            s.glitch <= `RST_GLITCH;
        end else begin
            s <= next_s;
        end
    end

    // Four identical channels
    for (genvar g = 0; g < 4; g++) begin : g_chan
        fan_chan u_chan (
            .clk       (REF_CLK),
            .nrst      (NRST),
            .pwm_cnt   (s.pwm_cnt),
            .duty      (duty[g]),
            .stretch   (force_v[g]),
            .enable    (s.started[g]),
            .tach      (TACH[g]),
            .fan_on    (FAN_ON[g]),
            .tach_rise (tach_rise[g])
        );
    end

    assign RDATA = s.rdata;

    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    sequence win_end_s;
        ms_tick && (s.slot_ms == WIN_LAST);
    endsequence

    sequence force_done_s;
        s.stretch && (s.edges == 2'h2) && (s.glitch_ms == 8'h00);
    endsequence

    chk_pwm_wrap: assert property (
        (step_tick && s.pwm_cnt == `FAN_PWM_LAST) |=> (s.pwm_cnt == 7'h00))
        else $error("PWM phase did not wrap after 99");

    chk_tach_latch: assert property (
        win_end_s |=> (s.tach_res[$past(s.meas_idx)] == $past(s.tach_cnt)))
        else $error("tach result not latched at window end");

    chk_rotation: assert property (
        win_end_s |=> (s.meas_idx == 2'($past(s.meas_idx) + 2'h1))
                      && (s.tach_cnt == 8'h00))
        else $error("measurement did not advance to next fan");

    chk_force_start: assert property (
        (win_end_s and s.rpt_en[next_idx]) |=> s.stretch
            ##1 (FAN_ON[s.meas_idx] || !$past(s.started[s.meas_idx])))
        else $error("reported fan not forced at window start");

    chk_force_hold: assert property (
        (s.stretch && !win_end && !(s.edges == 2'h2 && s.glitch_ms == 8'h00))
        |=> s.stretch)
        else $error("force released before glitch delay and two edges");

    chk_force_drop: assert property (
        (force_done_s and !win_end) |=> !s.stretch)
        else $error("force held after its release condition");

    chk_force_cap: assert property (
        (win_end_s and !s.rpt_en[next_idx]) |=> !s.stretch)
        else $error("stretched pulse outlived its window");

    chk_failsafe: assert property (
        ((fs_act & s.started) != 4'h0)
        |=> ((FAN_ON & $past(fs_act & s.started))
             == $past(fs_act & s.started)))
        else $error("fail-safe fan not driven full");

    chk_boot_default: assert property (
        (s.phase == PH_BOOT && !BOOT_SAVED && !WR)
        |=> (s.power == {4{`FAN_DUTY_FULL}}))
        else $error("default boot power is not full");

    chk_start_gap: assert property (
        $rose(s.started[1]) |-> ($past(s.gap_ms) == 9'h000))
        else $error("fan started inside the start-up gap");

    chk_link_loss: assert property (
        (!s.lk_s2 && (&s.started)) |=> (&FAN_ON))
        else $error("fans not full on after link loss");

    chk_cfg_write: assert property (
        (WR && ADDR == `OFS_GLITCH) |=> (s.glitch == $past(WDATA)))
        else $error("glitch delay write not taken");

    // Read data stand for the one cycle after the strobe only
    chk_rdata_idle: assert property (
        !RD |=> (RDATA == 8'h00))
        else $error("read data seen outside its cycle");

    // The clamp keeps every stored power within full scale
    chk_power_range: assert property (
        (WR && ADDR[3:2] == 2'b00)
        |=> (s.power[$past(ADDR[1:0])] <= `FAN_DUTY_FULL))
        else $error("stored power above full scale");

    // No fan is started while the start-up gap still runs
    chk_gap_hold: assert property (
        (s.phase == PH_START && s.gap_ms != 9'h000) |=> $stable(s.started))
        else $error("start-up gap cut short");

    // Channels not yet started keep their switch open
    chk_idle_off: assert property (
        (s.started == 4'h0) |=> (FAN_ON == 4'h0))
        else $error("fan on before start-up enabled it");

    // A power write is the host refresh and restarts the fail-safe age
    chk_fs_refresh: assert property (
        (WR && ADDR[3:2] == 2'b00)
        |=> (s.fs_cnt[$past(ADDR[1:0])] == 8'h00))
        else $error("power write did not refresh the fail-safe");

    // While stretching, the measured fan is held on whatever its duty
    chk_force_on: assert property (
        s.stretch |=> (FAN_ON[$past(s.meas_idx)]
                       || !$past(s.started[s.meas_idx])))
        else $error("stretched fan not held on");

    // Status read returns the started and fail-safe flags
    chk_status_read: assert property (
        (RD && ADDR == `OFS_STATUS)
        |=> (RDATA == $past({fs_act, s.started})))
        else $error("status read does not match state");

endmodule : fan_ctrl
`default_nettype wire

// >>> verilog/fan_map.svh
// Constants of the fan power and tachometer controller
`ifndef FAN_MAP_SVH
`define FAN_MAP_SVH

// Clock and timing, times in their own units
`define FAN_CLK_HZ     100000000
`define FAN_PWM_HZ     18
`define FAN_DUTY_STEPS 100
`define FAN_STEP_CYC   (`FAN_CLK_HZ / (`FAN_PWM_HZ * `FAN_DUTY_STEPS))
`define FAN_MS_CYC     (`FAN_CLK_HZ / 1000)
`define FAN_WIN_MS     125
`define FAN_GAP_MS     500

// Duty values
`define FAN_DUTY_FULL  8'h64
`define FAN_PWM_LAST   7'h63

// Register offsets
`define OFS_POWER0     4'h0
`define OFS_RPT_EN     4'h4
`define OFS_FS_EN      4'h5
`define OFS_FS_TMO     4'h6
`define OFS_GLITCH     4'h7
`define OFS_TACH0      4'h8
`define OFS_STATUS     4'hC

// Status fields
`define ST_STARTED_LSB 0
`define ST_FS_LSB      4

// Reset values
`define RST_FS_TMO     8'h08
`define RST_GLITCH     8'h01

`endif

// >>> verilog/fan_pkg.sv
// Types of the fan power and tachometer controller
`default_nettype none

package fan_pkg;

    typedef enum logic [1:0] {
        PH_BOOT,
        PH_START,
        PH_RUN
    } phase_t;

    typedef struct packed {
        logic            lk_s1;
        logic            lk_s2;
        phase_t          phase;
        logic [3:0][7:0] power;
        logic [3:0]      rpt_en;
        logic [3:0]      fs_en;
        logic [7:0]      fs_tmo;
        logic [7:0]      glitch;
        logic [3:0][7:0] tach_res;
        logic [7:0]      tach_cnt;
        logic [3:0][7:0] fs_cnt;
        logic [23:0]     ms_div;
        logic [23:0]     step_div;
        logic [6:0]      pwm_cnt;
        logic [6:0]      slot_ms;
        logic [1:0]      meas_idx;
        logic [1:0]      edges;
        logic [7:0]      glitch_ms;
        logic            stretch;
        logic [2:0]      st_idx;
        logic [8:0]      gap_ms;
        logic [3:0]      started;
        logic [7:0]      rdata;
    } ctrl_t;

    typedef struct packed {
        logic t_s1;
        logic t_s2;
        logic t_prev;
        logic on;
    } chan_t;

endpackage : fan_pkg

`default_nettype wire

// >>> verilog/fan_chan.sv
// One fan channel: switch drive and tachometer edge detect
`timescale 1ns/10ps
`default_nettype none
`include "fan_map.svh"

module fan_chan
    import fan_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Control
    input  wire logic [6:0] pwm_cnt,
    input  wire logic [7:0] duty,
    input  wire logic       stretch,
    input  wire logic       enable,
    // Fan side
    input  wire logic       tach,
    output logic            fan_on,
    output logic            tach_rise
);

    chan_t s;
    chan_t next_s;

    // Sync the tach pin, then compare phase against duty
    always_comb begin
        next_s        = s;
        next_s.t_s1   = tach;
        next_s.t_s2   = s.t_s1;
        next_s.t_prev = s.t_s2;
        // Duty 100 keeps it on, since the phase never passes 99
        next_s.on = enable & (stretch | ({1'b0, pwm_cnt} < duty));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Tach idles high on its pull-up; resetting the edge
            // detector to that level avoids a false edge after reset
            s <= '{t_s1: 1'b1, t_s2: 1'b1, t_prev: 1'b1, on: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign fan_on    = s.on;
    assign tach_rise = s.t_s2 & ~s.t_prev;

    // Full duty must hold the switch on
    chk_full_duty: assert property (@(posedge clk) disable iff (!nrst)
        (enable && duty == `FAN_DUTY_FULL) |=> fan_on)
        else $error("full duty did not switch fan on");

endmodule : fan_chan
`default_nettype wire

// >>> test/fan_model.sv
// Behavioural three-pin fan with a pulled-up tach output
`timescale 1ns/10ps
`default_nettype none

module fan_model #(
    parameter int HALF = 10
) (
    // Clock
    input  wire logic clk,
    // Drive and fault
    input  wire logic power_on,
    input  wire logic stall,
    // Tach pin
    output logic      tach
);
    int half_cnt = 0;

    // Spins only while powered; pull-up holds tach high when stopped,
    // so a stalled or unpowered fan gives no edges at all
    always @(posedge clk) begin
        if (!power_on || stall) begin
            tach     <= 1'b1;
            half_cnt <= 0;
        end else if (half_cnt == HALF - 1) begin
            tach     <= ~tach;
            half_cnt <= 0;
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end
endmodule : fan_model

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the four-channel fan controller
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import fan_pkg::*;
    // Shortened millisecond keeps the run short
    localparam int MS = 10;
    localparam int WIN = 125 * MS;
    localparam int GAP = 500 * MS;
    localparam int HALVES [4] = '{10, 20, 25, 50};
    localparam logic [7:0] DUTIES [5] = '{8'h00, 8'h01, 8'h19, 8'h63, 8'h64};

    typedef struct packed {
        logic       w;
        logic [3:0] a;
        logic [7:0] d;
    } row_t;

    logic        REF_CLK;
    logic        NRST;
    logic [3:0]  ADDR;
    logic [7:0]  WDATA;
    logic        WR;
    logic        RD;
    logic [7:0]  RDATA;
    logic        BOOT_SAVED;
    logic [31:0] BOOT_POWER;
    logic        LINK_OK;
    logic [3:0]  TACH;
    logic [3:0]  FAN_ON;
    logic [3:0]  stall;
    logic [7:0]  rv;
    int          failures;
    int          samples_checked;
    int          cyc;
    int          n;
    int          first_on [4];

    // Reads give expected value, writes give data
    row_t rows [18] = '{
        '{0, 4'h0, 8'h64}, '{0, 4'h1, 8'h64}, '{0, 4'h2, 8'h64},
        '{0, 4'h3, 8'h64}, '{0, 4'h4, 8'h00}, '{0, 4'h5, 8'h00},
        '{0, 4'h6, 8'h08}, '{0, 4'h7, 8'h01}, '{0, 4'h8, 8'h00},
        '{1, 4'h0, 8'hC8}, '{0, 4'h0, 8'h64}, '{1, 4'h8, 8'h55},
        '{0, 4'h8, 8'h00}, '{0, 4'hD, 8'h00}, '{1, 4'h6, 8'h03},
        '{0, 4'h6, 8'h03}, '{1, 4'h2, 8'h00}, '{0, 4'h2, 8'h00}};

    fan_ctrl #(.MS_CYC(MS), .STEP_CYC(4)) i_fan_ctrl (
        .REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .BOOT_SAVED(BOOT_SAVED),
        .BOOT_POWER(BOOT_POWER), .LINK_OK(LINK_OK), .TACH(TACH),
        .FAN_ON(FAN_ON));

    // One fan per channel, each at its own speed
    for (genvar g = 0; g < 4; g++) begin : g_fan
        fan_model #(.HALF(HALVES[g])) i_fan_model (
            .clk(REF_CLK), .power_on(FAN_ON[g]), .stall(stall[g]),
            .tach(TACH[g]));
    end

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    task automatic close_out();
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic check_rng(string name, int lo, int hi, int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_rng

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge REF_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [3:0] a);
        @(posedge REF_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 rv = RDATA;
    endtask : rd

    task automatic cycles(int k);
        repeat (k) @(posedge REF_CLK);
    endtask : cycles

    task automatic count_on(int i, int k);
        n = 0;
        repeat (k) begin
            @(posedge REF_CLK);
            n += int'(FAN_ON[i] === 1'b1);
        end
    endtask : count_on

    // Length of the next on pulse of fan 0, bounded both ways
    task automatic pulse();
        int t;
        t = 0;
        while (FAN_ON[0] !== 1'b1 && t < 6000) begin
            @(posedge REF_CLK);
            t++;
        end
        n = 0;
        while (FAN_ON[0] === 1'b1 && n < 2000) begin
            @(posedge REF_CLK);
            n++;
        end
    endtask : pulse

    task automatic do_reset(logic boot);
        @(posedge REF_CLK);
        NRST       <= 1'b0;
        BOOT_SAVED <= boot;
        repeat (4) @(posedge REF_CLK);
        check("reset fan_on", 8'h00, {4'h0, FAN_ON});
        check("reset rdata", 8'h00, RDATA);
        foreach (first_on[i]) first_on[i] = -1;
        NRST <= 1'b1;
    endtask : do_reset

    // Cycle count, first switch-on per fan, and hang limit
    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 4; i++) begin
            if (FAN_ON[i] === 1'b1 && first_on[i] < 0) first_on[i] <= cyc;
        end
        if (cyc == 80000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        {NRST, WR, RD, BOOT_SAVED, ADDR, WDATA, stall} = '0;
        BOOT_POWER = 32'h0;
        LINK_OK = 1'b1;
        {failures, samples_checked, cyc} = '0;
        @(posedge REF_CLK);
        do_reset(1'b0);
        // Register table, clamp, read-only and unmapped places
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a);
                check($sformatf("reg %h", rows[i].a), rows[i].d, rv);
            end
        end
        // Saved boot power; idle fan1 must not cost a gap
        BOOT_POWER <= 32'hC8640064;
        do_reset(1'b1);
        for (int i = 0; i < 4; i++) begin
            rd(4'(i));
            check("boot power", (i == 1) ? 8'h00 : 8'h64, rv);
        end
        n = 0;
        while (first_on[3] < 0 && n < 3 * GAP) begin
            @(posedge REF_CLK);
            n++;
        end
        check_rng("gap 0-2", GAP - 10, GAP + 10, first_on[2] - first_on[0]);
        check_rng("gap 2-3", GAP - 10, GAP + 10, first_on[3] - first_on[2]);
        check_rng("idle fan1", -1, -1, first_on[1]);
        rd(4'hC);
        check("started", 8'h0F, rv);
        // Full power everywhere, two whole rotations
        wr(4'h1, 8'h64);
        cycles(8 * WIN);
        for (int i = 0; i < 4; i++) begin
            rd(4'(8 + i));
            n = WIN / (2 * HALVES[i]);
            check_rng("tach", n - 1, n + 1, int'(rv));
        end
        // Five duties, 0 to full, each hold the fan on for its share of each PWM period
        foreach (DUTIES[i]) begin
            wr(4'h0, DUTIES[i]);
            cycles(400);
            count_on(0, 1600);
            check_rng("duty", DUTIES[i] * 16, DUTIES[i] * 16, n);
        end
        // Forced pulse on an otherwise off fan
        wr(4'h0, 8'h00);
        wr(4'h4, 8'h01);
        pulse();
        check_rng("forced on", 38, 52, n);
        wr(4'h7, 8'h0A);
        pulse();
        check_rng("glitch hold", 9 * MS, 11 * MS + 8, n);
        stall[0] <= 1'b1;
        pulse();
        check_rng("stretch cap", WIN - 10, WIN + 2, n);
        stall[0] <= 1'b0;
        wr(4'h4, 8'h00);
        // Host falls silent on a fail-safe fan
        wr(4'h3, 8'h00);
        wr(4'h6, 8'h02);
        wr(4'h5, 8'h08);
        cycles(WIN - 300);
        rd(4'hC);
        check("fs idle", 8'h0F, rv);
        cycles(2 * WIN + 300);
        rd(4'hC);
        check("fs active", 8'h8F, rv);
        count_on(3, 100);
        check_rng("fs full", 100, 100, n);
        wr(4'h3, 8'h00);
        rd(4'hC);
        check("fs refresh", 8'h0F, rv);
        wr(4'h5, 8'h00);
        // Lost link forces every fan on, even at zero duty
        LINK_OK <= 1'b0;
        cycles(5);
        n = 0;
        repeat (400) begin
            @(posedge REF_CLK);
            n += int'(FAN_ON === 4'hF);
        end
        check_rng("link loss", 400, 400, n);
        LINK_OK <= 1'b1;
        cycles(6);
        check("link back", 8'h00, {7'h0, FAN_ON[0]});
        close_out();
    end
endmodule : tb_top

`default_nettype wire
